//--- include/cms_params.svh
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define CMS_IDX_MUTE        8'h03
`define CMS_IDX_PLL         8'h04
`define CMS_IDX_OSC         8'h05
`define CMS_IDX_IRQ_STATUS  8'h10
`define CMS_IDX_IRQ_MASK    8'h11

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CMS_BIT_FRAME_CLK   7
`define CMS_BIT_BUF_EN      6
`define CMS_BIT_POWERUP     5
`define CMS_BIT_MUTE_L      4
`define CMS_BIT_MUTE_R      0
`define CMS_BIT_PLL_UNLOCK  4
`define CMS_BIT_PLL_EN      0
`define CMS_BIT_OSC_SEL     5
`define CMS_BIT_OSC_PD      4
`define CMS_BIT_OSC_AUTO    0
`define CMS_IRQ_WIDTH       5

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CMS_RST_MUTE        1'b0
`define CMS_RST_PLL_EN      1'b1
`define CMS_RST_PLL_UNLOCK  1'b0
`define CMS_RST_OSC_AUTO    1'b1
`define CMS_RST_IRQ_MASK    5'h00

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CMS_CLK_NS          20
`define CMS_FRAME_DIV_BITS  10
`define CMS_RAMP_STEP_NS    1000
`define CMS_RAMP_STEP_CYC   ((`CMS_RAMP_STEP_NS + `CMS_CLK_NS - 1) / `CMS_CLK_NS)
`define CMS_RAMP_CNT_BITS   6
`define CMS_GAIN_FULL       8'hff
`define CMS_GAIN_MUTE       8'h00

`endif

//--- include/cms_pkg.sv
package cms_pkg;

	// Power-on detections feeding the backend status bits
	typedef struct packed {
		logic ldo_in_por;
		logic ldo_out_por;
		logic analog_supply_por;
		logic charge_pump_supply_por;
		logic line_amp_unmuted;
	} cms_power_type;

	// Clock-source status from the clock tree
	typedef struct packed {
		logic pll_locked;
		logic osc_in_use;
		logic osc_needed;
		logic clock_error;
	} cms_clk_status_type;

	// Ramp engine states
	typedef enum logic [1:0] {
		CMS_RAMP_IDLE = 2'b00,
		CMS_RAMP_DOWN = 2'b01,
		CMS_RAMP_UP   = 2'b10
	} cms_ramp_state_type;

endpackage : cms_pkg

//--- logic/cms_vol_ramp.sv
`timescale 1ns/10ps
`include "cms_params.svh"

module cms_vol_ramp (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	input  wire logic       mute_req,
	output logic [7:0]      gain,
	output logic            ramp_done
);

	cms_pkg::cms_ramp_state_type        state;
	logic [`CMS_RAMP_CNT_BITS-1:0]      step_cnt;
	logic                               step_tick;

	// ---------------------------------------------------------------
	// Step timer
	// ---------------------------------------------------------------
	assign step_tick = (step_cnt == `CMS_RAMP_CNT_BITS'(`CMS_RAMP_STEP_CYC - 1));

	// Paces gain steps while ramping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			step_cnt <= '0;
		else if (ce) begin
			if (state == cms_pkg::CMS_RAMP_IDLE || step_tick)
				step_cnt <= '0;
			else
				step_cnt <= step_cnt + `CMS_RAMP_CNT_BITS'(1);
		end
	end

	// ---------------------------------------------------------------
	// Ramp state and gain
	// ---------------------------------------------------------------
	// Gain walks one step at a time, never jumps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= cms_pkg::CMS_RAMP_IDLE;
			gain      <= `CMS_GAIN_FULL;
			ramp_done <= 1'b0;
		end else if (ce) begin
			ramp_done <= 1'b0;
			unique case (state)
				cms_pkg::CMS_RAMP_IDLE: begin
					if (mute_req && gain != `CMS_GAIN_MUTE)
						state <= cms_pkg::CMS_RAMP_DOWN;
					else if (!mute_req && gain != `CMS_GAIN_FULL)
						state <= cms_pkg::CMS_RAMP_UP;
				end
				cms_pkg::CMS_RAMP_DOWN: begin
					if (!mute_req)
						state <= cms_pkg::CMS_RAMP_UP;  // Reverse mid-ramp
					else if (step_tick) begin
						gain <= gain - 8'h01;
						if (gain == 8'h01) begin
							state     <= cms_pkg::CMS_RAMP_IDLE;
							ramp_done <= 1'b1;
						end
					end
				end
				cms_pkg::CMS_RAMP_UP: begin
					if (mute_req)
						state <= cms_pkg::CMS_RAMP_DOWN;  // Reverse mid-ramp
					else if (step_tick) begin
						gain <= gain + 8'h01;
						if (gain == 8'hfe) begin
							state     <= cms_pkg::CMS_RAMP_IDLE;
							ramp_done <= 1'b1;
						end
					end
				end
				default: state <= cms_pkg::CMS_RAMP_IDLE;
			endcase
		end
	end

endmodule : cms_vol_ramp

//--- logic/cms_regs.sv
`timescale 1ns/10ps
`include "cms_params.svh"

module cms_regs (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       ce,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [9:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire cms_pkg::cms_power_type     power_status,
	input  wire cms_pkg::cms_clk_status_type clk_status,
	input  wire logic                       standby_request,
	output logic                            backend_frame_clk,
	output logic                            pll_enable,
	output logic                            mclk_select_external,
	output logic                            osc_power_enable,
	output logic                            standby_force,
	output logic      [7:0]                 left_gain,
	output logic      [7:0]                 right_gain,
	output logic                            irq
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic                               left_soft_mute_request;
	logic                               right_soft_mute_request;
	logic                               pll_enable_bit;
	logic                               fallback_osc_auto_off;
	logic                               pll_unlocked_flag;
	logic                               backend_buffer_enable_status;
	logic                               backend_powerup_status;
	logic                               fallback_osc_selected;
	logic                               fallback_osc_powered_down;
	logic [`CMS_FRAME_DIV_BITS-1:0]     frame_cnt;
	logic [`CMS_IRQ_WIDTH-1:0]          irq_status;
	logic [`CMS_IRQ_WIDTH-1:0]          irq_mask;
	logic [`CMS_IRQ_WIDTH-1:0]          irq_event;
	logic [`CMS_IRQ_WIDTH-1:0]          next_irq_status;
	logic                               unlock_prev;
	logic                               clk_err_prev;
	logic                               osc_sel_prev;
	logic                               left_done;
	logic                               right_done;
	logic                               access;
	logic                               complete;
	logic                               wr_done;
	logic                               rd_done;
	logic                               hit;
	logic [7:0]                         rd_value;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Byte address of a register index
	function automatic logic [9:0] byte_addr(input logic [7:0] idx);
		byte_addr = {idx, 2'b00};
	endfunction : byte_addr

	// True when the bus address selects a register index
	function automatic logic addr_is(input logic [9:0] addr, input logic [7:0] idx);
		addr_is = (addr == byte_addr(idx));
	endfunction : addr_is

	// ---------------------------------------------------------------
	// APB handshake
	// ---------------------------------------------------------------
	assign access   = psel && penable;
	assign complete = access && pready;
	assign wr_done  = complete && pwrite;
	assign rd_done  = access && !pready && !pwrite;  // Same edge that captures read data
	assign hit      = addr_is(paddr, `CMS_IDX_MUTE) || addr_is(paddr, `CMS_IDX_PLL) ||
	                  addr_is(paddr, `CMS_IDX_OSC) || addr_is(paddr, `CMS_IDX_IRQ_STATUS) ||
	                  addr_is(paddr, `CMS_IDX_IRQ_MASK);

	// One wait state, then ready with data and error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (ce) begin
			pready  <= access && !pready;
			pslverr <= access && !pready && !hit;
			if (access && !pready && (!pwrite || !hit))
				prdata <= {24'h00_0000, rd_value};  // Zero on any refused access
		end
	end

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	// Reserved bits fill with zero
	always_comb begin
		rd_value = 8'h00;
		if (addr_is(paddr, `CMS_IDX_MUTE)) begin
			rd_value[`CMS_BIT_FRAME_CLK] = backend_frame_clk;
			rd_value[`CMS_BIT_BUF_EN]    = backend_buffer_enable_status;
			rd_value[`CMS_BIT_POWERUP]   = backend_powerup_status;
			rd_value[`CMS_BIT_MUTE_L]    = left_soft_mute_request;
			rd_value[`CMS_BIT_MUTE_R]    = right_soft_mute_request;
		end else if (addr_is(paddr, `CMS_IDX_PLL)) begin
			rd_value[`CMS_BIT_PLL_UNLOCK] = pll_unlocked_flag;
			rd_value[`CMS_BIT_PLL_EN]     = pll_enable_bit;
		end else if (addr_is(paddr, `CMS_IDX_OSC)) begin
			rd_value[`CMS_BIT_OSC_SEL]  = fallback_osc_selected;
			rd_value[`CMS_BIT_OSC_PD]   = fallback_osc_powered_down;
			rd_value[`CMS_BIT_OSC_AUTO] = fallback_osc_auto_off;
		end else if (addr_is(paddr, `CMS_IDX_IRQ_STATUS)) begin
			rd_value[`CMS_IRQ_WIDTH-1:0] = irq_status;
		end else if (addr_is(paddr, `CMS_IDX_IRQ_MASK)) begin
			rd_value[`CMS_IRQ_WIDTH-1:0] = irq_mask;
		end
	end

	// ---------------------------------------------------------------
	// Writable control bits
	// ---------------------------------------------------------------
	// Mute requests, only their own bits are stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_soft_mute_request  <= `CMS_RST_MUTE;
			right_soft_mute_request <= `CMS_RST_MUTE;
		end else if (ce && wr_done && addr_is(paddr, `CMS_IDX_MUTE)) begin
			left_soft_mute_request  <= pwdata[`CMS_BIT_MUTE_L];
			right_soft_mute_request <= pwdata[`CMS_BIT_MUTE_R];
		end
	end

	// PLL enable control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pll_enable_bit <= `CMS_RST_PLL_EN;
		else if (ce && wr_done && addr_is(paddr, `CMS_IDX_PLL))
			pll_enable_bit <= pwdata[`CMS_BIT_PLL_EN];
	end

	// Oscillator auto-off control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fallback_osc_auto_off <= `CMS_RST_OSC_AUTO;
		else if (ce && wr_done && addr_is(paddr, `CMS_IDX_OSC))
			fallback_osc_auto_off <= pwdata[`CMS_BIT_OSC_AUTO];
	end

	// Interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_mask <= `CMS_RST_IRQ_MASK;
		else if (ce && wr_done && addr_is(paddr, `CMS_IDX_IRQ_MASK))
			irq_mask <= pwdata[`CMS_IRQ_WIDTH-1:0];
	end

	// ---------------------------------------------------------------
	// Status bits
	// ---------------------------------------------------------------
	// Backend and clock status, sampled each cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			backend_buffer_enable_status <= 1'b0;
			backend_powerup_status       <= 1'b0;
			pll_unlocked_flag            <= `CMS_RST_PLL_UNLOCK;
			fallback_osc_selected        <= 1'b0;
			fallback_osc_powered_down    <= 1'b0;
		end else if (ce) begin
			backend_buffer_enable_status <= power_status.ldo_in_por &&
			                                power_status.ldo_out_por;
			backend_powerup_status       <= power_status.analog_supply_por &&
			                                power_status.charge_pump_supply_por &&
			                                power_status.line_amp_unmuted;
			pll_unlocked_flag            <= !pll_enable_bit ||
			                                !clk_status.pll_locked;
			fallback_osc_selected        <= clk_status.osc_in_use;
			fallback_osc_powered_down    <= fallback_osc_auto_off &&
			                                !clk_status.osc_in_use &&
			                                !clk_status.osc_needed;
		end
	end

	// Clock source and standby controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_enable           <= `CMS_RST_PLL_EN;
			mclk_select_external <= !`CMS_RST_PLL_EN;
			osc_power_enable     <= 1'b1;
			standby_force        <= 1'b0;
		end else if (ce) begin
			pll_enable           <= pll_enable_bit;
			mclk_select_external <= !pll_enable_bit;
			osc_power_enable     <= !(fallback_osc_auto_off && !clk_status.osc_in_use &&
			                          !clk_status.osc_needed);
			standby_force        <= standby_request || clk_status.clock_error;
		end
	end

	// ---------------------------------------------------------------
	// Backend frame clock
	// ---------------------------------------------------------------
	// Divide by 1024, held low in standby
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_cnt         <= '0;
			backend_frame_clk <= 1'b0;
		end else if (ce) begin
			if (standby_force) begin
				frame_cnt         <= '0;
				backend_frame_clk <= 1'b0;
			end else begin
				frame_cnt         <= frame_cnt + `CMS_FRAME_DIV_BITS'(1);
				backend_frame_clk <= frame_cnt[`CMS_FRAME_DIV_BITS-1];
			end
		end
	end

	// ---------------------------------------------------------------
	// Volume ramps
	// ---------------------------------------------------------------
	// Left channel soft mute
	cms_vol_ramp u_ramp_left (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.mute_req  (left_soft_mute_request),
		.gain      (left_gain),
		.ramp_done (left_done)
	);

	// Right channel soft mute
	cms_vol_ramp u_ramp_right (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.mute_req  (right_soft_mute_request),
		.gain      (right_gain),
		.ramp_done (right_done)
	);

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------
	// Edge history for event detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock_prev  <= 1'b0;
			clk_err_prev <= 1'b0;
			osc_sel_prev <= 1'b0;
		end else if (ce) begin
			unlock_prev  <= pll_unlocked_flag;
			clk_err_prev <= clk_status.clock_error;
			osc_sel_prev <= fallback_osc_selected;
		end
	end

	// Lock lost, clock error, oscillator taken over, ramps finished
	assign irq_event = {right_done, left_done,
	                    fallback_osc_selected && !osc_sel_prev,
	                    clk_status.clock_error && !clk_err_prev,
	                    pll_unlocked_flag && !unlock_prev};

	// Read of the status clears it; a new event wins
	always_comb begin
		next_irq_status = irq_status;
		if (rd_done && addr_is(paddr, `CMS_IDX_IRQ_STATUS))
			next_irq_status = '0;
		next_irq_status = next_irq_status | irq_event;
	end

	// Sticky status and level interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
			irq        <= 1'b0;
		end else if (ce) begin
			irq_status <= next_irq_status;
			irq        <= |(next_irq_status & irq_mask);
		end
	end

endmodule : cms_regs

//--- bench/cms_regs_chk.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Port checker for the register bank
// ---------------------------------------------------------------
module cms_regs_chk (
	input wire logic                        pclk,
	input wire logic                        presetn,
	input wire logic                        ce,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [9:0]                  paddr,
	input wire logic [31:0]                 pwdata,
	input wire logic [31:0]                 prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire cms_pkg::cms_power_type      power_status,
	input wire cms_pkg::cms_clk_status_type clk_status,
	input wire logic                        standby_request,
	input wire logic                        backend_frame_clk,
	input wire logic                        pll_enable,
	input wire logic                        mclk_select_external,
	input wire logic                        osc_power_enable,
	input wire logic                        standby_force,
	input wire logic [7:0]                  left_gain,
	input wire logic [7:0]                  right_gain,
	input wire logic                        irq
);
	logic       sb_cause;
	logic       fclk_q;
	logic [9:0] half_cnt;
	logic       half_dirty;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Either standby source
	assign sb_cause = standby_request | clk_status.clock_error;

	// Length of each frame clock phase, marked when standby or freeze intervenes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fclk_q     <= 1'b0;
			half_cnt   <= 10'h000;
			half_dirty <= 1'b0;
		end else begin
			fclk_q <= backend_frame_clk;
			if (backend_frame_clk != fclk_q) begin
				half_cnt   <= 10'h000;
				half_dirty <= standby_force | !ce;
			end else begin
				half_cnt   <= half_cnt + 10'h001;
				half_dirty <= half_dirty | standby_force | !ce;
			end
		end
	end

	mclk_sel_a: assert property (mclk_select_external == !pll_enable)
		else $error("external clock select is not the inverse of pll enable");
	standby_cause_a: assert property ($past(presetn) && $past(ce) |-> standby_force == $past(sb_cause))
		else $error("standby force does not follow its causes");
	frame_stop_a: assert property (standby_force [*2] |-> !backend_frame_clk)
		else $error("frame clock runs in standby");
	frame_half_a: assert property (backend_frame_clk != fclk_q && !backend_frame_clk && !half_dirty && !standby_force
		|-> half_cnt == 10'h1ff)
		else $error("frame clock high phase is not 512 cycles");
	ready_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("access not answered after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	err_zero_a: assert property (pslverr |-> pready && prdata == 32'h00000000)
		else $error("error response without ready or with data");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read data bits not zero");
	gain_left_a: assert property ($past(presetn) && left_gain != $past(left_gain)
		|-> (left_gain == $past(left_gain) + 8'h01 || left_gain == $past(left_gain) - 8'h01)
		##1 $stable(left_gain) [*8])
		else $error("left gain stepped abruptly");
	gain_right_a: assert property ($past(presetn) && right_gain != $past(right_gain)
		|-> (right_gain == $past(right_gain) + 8'h01 || right_gain == $past(right_gain) - 8'h01)
		##1 $stable(right_gain) [*8])
		else $error("right gain stepped abruptly");

	// Main scenarios reached
	cov_err: cover property (pslverr);
	cov_standby: cover property ($rose(standby_force));
	cov_irq: cover property ($rose(irq));
	cov_ramp: cover property (left_gain == 8'h00);
endmodule : cms_regs_chk

bind cms_regs cms_regs_chk u_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .power_status, .clk_status, .standby_request, .backend_frame_clk, .pll_enable,
	.mclk_select_external, .osc_power_enable, .standby_force, .left_gain, .right_gain, .irq);

//--- bench/clock_mute_status_regs_test.sv
`timescale 1ns/10ps
`include "cms_params.svh"

module clock_mute_status_regs_test;
	logic                        pclk;
	logic                        presetn;
	logic                        ce;
	logic                        psel;
	logic                        penable;
	logic                        pwrite;
	logic [9:0]                  paddr;
	logic [31:0]                 pwdata;
	logic [31:0]                 prdata;
	logic                        pready;
	logic                        pslverr;
	cms_pkg::cms_power_type      power_status;
	cms_pkg::cms_clk_status_type clk_status;
	logic                        standby_request;
	logic                        backend_frame_clk;
	logic                        pll_enable;
	logic                        mclk_select_external;
	logic                        osc_power_enable;
	logic                        standby_force;
	logic [7:0]                  left_gain;
	logic [7:0]                  right_gain;
	logic                        irq;
	int                          err_total;
	int                          check_count;
	logic [31:0]                 rdv;
	logic                        rerr;
	logic [7:0]                  g;
	logic                        fq;
	int                          n;

	cms_regs DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.power_status, .clk_status, .standby_request, .backend_frame_clk, .pll_enable, .mclk_select_external,
		.osc_power_enable, .standby_force, .left_gain, .right_gain, .irq);

	// ---------------------------------------------------------------
	// Clock, compare, bus and closing tasks
	// ---------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// One transfer, held until ready, then released for a cycle
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int k;
		k = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rdv  = prdata;
		rerr = pslverr;
		chk(k, 2, "wait cycles");
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic eerr);
		apb(1'b0, idx, 8'h00);
		chk(rdv, {24'h000000, exp}, "read data");
		chk({31'h0, rerr}, {31'h0, eerr}, "read error");
	endtask : rd_chk

	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic eerr);
		apb(1'b1, idx, d);
		chk({31'h0, rerr}, {31'h0, eerr}, "write error");
	endtask : wr

	task automatic conclude;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// Watchdog against a hang
	initial begin
		repeat (60000) @(posedge pclk);
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end

	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial begin
		err_total = 0;
		check_count = 0;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h000;
		pwdata = 32'h00000000;
		power_status = 5'h00;
		clk_status = 4'h8;
		standby_request = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		rd_chk(`CMS_IDX_MUTE, 8'h00, 1'b0);
		rd_chk(`CMS_IDX_PLL, 8'h01, 1'b0);
		rd_chk(`CMS_IDX_OSC, 8'h11, 1'b0);
		rd_chk(`CMS_IDX_IRQ_MASK, 8'h00, 1'b0);
		chk({left_gain, right_gain}, 16'hffff, "gains");
		// Every power detection combination
		for (int i = 0; i < 32; i++) begin
			power_status <= cms_pkg::cms_power_type'(i[4:0]);
			repeat (2) @(posedge pclk);
			rd_chk(`CMS_IDX_MUTE, {1'b0, i[4] & i[3], i[2] & i[1] & i[0], 5'h00}, 1'b0);
		end
		// Every lock and oscillator combination
		for (int i = 0; i < 8; i++) begin
			clk_status <= cms_pkg::cms_clk_status_type'({i[2:0], 1'b0});
			repeat (2) @(posedge pclk);
			rd_chk(`CMS_IDX_PLL, {3'h0, !i[2], 4'h1}, 1'b0);
			rd_chk(`CMS_IDX_OSC, {2'h0, i[1], !i[1] & !i[0], 4'h1}, 1'b0);
			chk(osc_power_enable, i[1] | i[0], "osc power");
		end
		clk_status <= 4'h8;
		power_status <= 5'h00;
		wr(`CMS_IDX_MUTE, 8'hee, 1'b0);
		rd_chk(`CMS_IDX_MUTE, 8'h00, 1'b0);
		wr(`CMS_IDX_PLL, 8'hfe, 1'b0);
		rd_chk(`CMS_IDX_PLL, 8'h10, 1'b0);
		chk({pll_enable, mclk_select_external}, 2'b01, "pll outputs");
		wr(`CMS_IDX_PLL, 8'h01, 1'b0);
		rd_chk(`CMS_IDX_PLL, 8'h01, 1'b0);
		wr(`CMS_IDX_OSC, 8'hfe, 1'b0);
		rd_chk(`CMS_IDX_OSC, 8'h00, 1'b0);
		chk(osc_power_enable, 1'b1, "osc kept on");
		wr(`CMS_IDX_OSC, 8'h01, 1'b0);
		rd_chk(`CMS_IDX_OSC, 8'h11, 1'b0);
		rd_chk(8'h06, 8'h00, 1'b1);
		wr(8'h00, 8'hff, 1'b1);
		// Clock error: standby, masked then unmasked interrupt
		apb(1'b0, `CMS_IDX_IRQ_STATUS, 8'h00);
		clk_status.clock_error <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({standby_force, irq}, 2'b10, "standby masked");
		rd_chk(`CMS_IDX_IRQ_STATUS, 8'h02, 1'b0);
		rd_chk(`CMS_IDX_IRQ_STATUS, 8'h00, 1'b0);
		wr(`CMS_IDX_IRQ_MASK, 8'h02, 1'b0);
		clk_status.clock_error <= 1'b0;
		@(posedge pclk);
		clk_status.clock_error <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(irq, 1'b1, "irq raised");
		rd_chk(`CMS_IDX_IRQ_STATUS, 8'h02, 1'b0);
		chk(irq, 1'b0, "irq cleared");
		clk_status.clock_error <= 1'b0;
		standby_request <= 1'b1;
		repeat (600) @(posedge pclk);
		chk({standby_force, backend_frame_clk}, 2'b10, "soft standby");
		standby_request <= 1'b0;
		// Left mute ramp with a freeze before its first gain step
		wr(`CMS_IDX_IRQ_MASK, 8'h18, 1'b0);
		wr(`CMS_IDX_MUTE, 8'h10, 1'b0);
		apb(1'b0, `CMS_IDX_MUTE, 8'h00);
		chk(rdv & 32'h0000007f, 32'h00000010, "left request");
		ce <= 1'b0;
		@(posedge pclk);
		g = left_gain;
		repeat (200) @(posedge pclk);
		chk(left_gain, g, "frozen gain");
		ce <= 1'b1;
		fq = backend_frame_clk;
		n = 0;
		repeat (2048) begin
			@(posedge pclk);
			n += int'(backend_frame_clk && !fq);
			fq = backend_frame_clk;
		end
		chk(n, 2, "frame rises");
		chk({left_gain > 8'h00 && left_gain < 8'hff, right_gain}, 9'h1ff, "mid ramp");
		n = 0;
		while (left_gain !== 8'h00 && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
		chk({left_gain, irq}, 9'h001, "left muted");
		rd_chk(`CMS_IDX_IRQ_STATUS, 8'h08, 1'b0);
		// Left back up, right down together
		wr(`CMS_IDX_MUTE, 8'h01, 1'b0);
		apb(1'b0, `CMS_IDX_MUTE, 8'h00);
		chk(rdv & 32'h0000007f, 32'h00000001, "right request");
		n = 0;
		while ((left_gain !== 8'hff || right_gain !== 8'h00) && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		chk(n > 12000, 1'b1, "ramp duration");
		repeat (60) @(posedge pclk);
		rd_chk(`CMS_IDX_IRQ_STATUS, 8'h18, 1'b0);
		conclude();
	end
endmodule : clock_mute_status_regs_test
